/* common/esc_consts.svh */
// Offsets, reset values, field positions and timing constants of the config bank
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH

// ----------------------------------------
// Word offsets
// ----------------------------------------
`define ESC_ADDR_SIG 4'h0
`define ESC_ADDR_VIDOPT 4'hA
`define ESC_ADDR_GLOBAL 4'hB
`define ESC_ADDR_RSVA 4'hC
`define ESC_ADDR_RSVB 4'hD
`define ESC_ADDR_LAST 4'hD
`define ESC_NUM_PORTS 6

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define ESC_SIG_DEFAULT 16'hA5C3
`define ESC_PORT_RESET 16'h040F
`define ESC_VIDOPT_RESET 16'h5902
`define ESC_GLOBAL_RESET 16'h8000
`define ESC_RSV_VALUE 16'h0FA5
`define ESC_PORT_MASK 16'hFFFF
`define ESC_VIDOPT_MASK 16'h0200
`define ESC_GLOBAL_MASK 16'h80C0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ESC_B_XOVER 15
`define ESC_B_FIBER 14
`define ESC_B_PORT_DEFAULT_VLAN_ID_HI 13
`define ESC_B_PORT_DEFAULT_VLAN_ID_LO 10
`define ESC_B_PRIO_HI 9
`define ESC_B_PRIO_LO 8
`define ESC_B_PORTPRIO 7
`define ESC_B_TOSFIRST 6
`define ESC_B_DISABLE 5
`define ESC_B_TAG 4
`define ESC_B_DUPLEX 3
`define ESC_B_SPEED 2
`define ESC_B_ANEG 1
`define ESC_B_FLOW 0
`define ESC_B_VIDREPL 9
`define ESC_B_FEFDIS 15
`define ESC_B_TRUNK 7
`define ESC_B_IPGLVL 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define ESC_IPG_SHORT 7'd92
`define ESC_IPG_STD 7'd96
`define ESC_STRAP_SETTLE 2'd3

`endif

/* common/esc_pkg.sv */
// Types shared by the switch configuration bank
package esc_pkg;

    typedef enum logic [2:0]
    {
        ST_STRAP = 3'b001,
        ST_FETCH = 3'b010,
        ST_DONE = 3'b100
    } esc_state_t;

    typedef struct packed
    {
        logic autoMdix;
        logic fiberMediaMode;
        logic [3:0] pvidLow;
        logic [1:0] portPrio;
        logic portPrioOnly;
        logic tosFirst;
        logic portDisable;
        logic egressTag;
        logic fullDuplex;
        logic speed100;
        logic autoNeg;
        logic flowCtl;
    } esc_port_cfg_t;

    typedef struct packed
    {
        logic valid;
        logic [2:0] port;
        logic hasVlan;
        logic [1:0] vlanPrio;
        logic hasTos;
        logic [1:0] tosPrio;
    } esc_prio_query_t;

endpackage

/* hw/esc_config_bank.sv */
// Switch configuration bank loaded from the serial configuration memory
`timescale 1ns/1ps
`include "esc_consts.svh"

module esc_config_bank
    import esc_pkg::*;
#(
    // Arbitrary neutral signature value
    parameter logic [15:0] SIGNATURE = `ESC_SIG_DEFAULT
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Reset straps (pins)
    input wire logic crossoverStrapPin,
    input wire logic portSevenFiberStrap,
    // Configuration memory word reader
    output logic eeReq,
    output logic [3:0] eeAddr,
    input wire logic eeValid,
    input wire logic [15:0] eeData,
    // Internal register programming
    input wire logic progWrEn,
    input wire logic [3:0] progAddr,
    input wire logic [15:0] progWrData,
    input wire logic [3:0] progRdAddr,
    output logic [15:0] progRdData,
    // Priority classification
    input wire logic tagMode,
    input wire esc_prio_query_t prioQuery,
    output logic prioValid,
    output logic [1:0] prioQueue,
    // Decoded configuration
    output esc_port_cfg_t [5:0] portCfg,
    output logic vidReplace,
    output logic farEndFaultDisable,
    output logic trunkEnable,
    output logic [6:0] ipgBitTimes,
    output logic loadDone,
    output logic signatureBad
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [3:0] portAddr(input int p);
        case (p)
            0: portAddr = 4'h1;
            1: portAddr = 4'h3;
            2: portAddr = 4'h5;
            3: portAddr = 4'h7;
            4: portAddr = 4'h8;
            default: portAddr = 4'h9;
        endcase
    endfunction

    function automatic logic [15:0] resetVal(input logic [3:0] a);
        if (a == `ESC_ADDR_VIDOPT)
            resetVal = `ESC_VIDOPT_RESET;
        else if (a == `ESC_ADDR_GLOBAL)
            resetVal = `ESC_GLOBAL_RESET;
        else
            resetVal = `ESC_PORT_RESET;
    endfunction

    function automatic logic [15:0] wrMask(input logic [3:0] a);
        if (a == `ESC_ADDR_VIDOPT)
            wrMask = `ESC_VIDOPT_MASK;
        else if (a == `ESC_ADDR_GLOBAL)
            wrMask = `ESC_GLOBAL_MASK;
        else
            wrMask = `ESC_PORT_MASK;
    endfunction

    // ----------------------------------------
    // Strap synchronisers and capture
    // ----------------------------------------
    logic [2:0] xoSync_q, xoSync_d, fxSync_q, fxSync_d;
    logic [1:0] strapCnt_q, strapCnt_d;
    logic xoStrap_q, xoStrap_d, fxStrap_q, fxStrap_d;
    logic strapsStable;

    assign strapsStable = (xoSync_q[1] == xoSync_q[2]) && (fxSync_q[1] == fxSync_q[2]);

    // ----------------------------------------
    // Loader and register state
    // ----------------------------------------
    esc_state_t state_q, state_d;
    logic [3:0] addr_q, addr_d;
    logic sigBad_q, sigBad_d;
    logic [15:0] words_q [1:11];
    logic [15:0] words_d [1:11];
    logic [15:0] rdData_q, rdData_d;
    logic [1:0] prio_q, prio_d;
    logic prioValid_q, prioValid_d;
    logic wrHit;
    logic [3:0] wrAddr;
    logic [15:0] wrData;
    logic [15:0] eff [1:11];

    always_comb
    begin
        xoSync_d = {xoSync_q[1:0], crossoverStrapPin};
        fxSync_d = {fxSync_q[1:0], portSevenFiberStrap};
        strapCnt_d = strapCnt_q;
        xoStrap_d = xoStrap_q;
        fxStrap_d = fxStrap_q;
        state_d = state_q;
        addr_d = addr_q;
        sigBad_d = sigBad_q;
        wrHit = 1'b0;
        wrAddr = progAddr;
        wrData = progWrData;
        eeReq = 1'b0;
        case (state_q)
            ST_STRAP:
            begin
                // Straps latch only once the pins have settled after release
                if (!strapsStable)
                    strapCnt_d = 2'd0;
                else if (strapCnt_q != `ESC_STRAP_SETTLE)
                    strapCnt_d = strapCnt_q + 2'd1;
                else
                begin
                    xoStrap_d = xoSync_q[2];
                    fxStrap_d = fxSync_q[2];
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                eeReq = 1'b1;
                if (eeValid)
                begin
                    if (addr_q == `ESC_ADDR_SIG && eeData != SIGNATURE)
                    begin
                        sigBad_d = 1'b1;
                        state_d = ST_DONE;
                    end
                    else
                    begin
                        if (addr_q != `ESC_ADDR_SIG && addr_q <= `ESC_ADDR_GLOBAL)
                        begin
                            wrHit = 1'b1;
                            wrAddr = addr_q;
                            wrData = eeData;
                        end
                        if (addr_q == `ESC_ADDR_LAST)
                            state_d = ST_DONE;
                        else
                            addr_d = addr_q + 4'd1;
                    end
                end
            end
            ST_DONE:
            begin
                // signature and reserved words refuse writes
                wrHit = progWrEn && progAddr != `ESC_ADDR_SIG
                    && progAddr <= `ESC_ADDR_GLOBAL;
            end
            default:
                state_d = ST_STRAP;
        endcase
        for (int i = 1; i <= 11; i++)
        begin
            if (wrHit && wrAddr == 4'(i))
                words_d[i] = (words_q[i] & ~wrMask(4'(i))) | (wrData & wrMask(4'(i)));
            else
                words_d[i] = words_q[i];
        end
    end

    always_comb
    begin
        for (int i = 1; i <= 11; i++)
            eff[i] = (state_q == ST_DONE) ? words_q[i] : resetVal(4'(i));
    end

    always_comb
    begin
        if (progRdAddr == `ESC_ADDR_SIG)
            rdData_d = SIGNATURE;
        else if (progRdAddr == `ESC_ADDR_RSVA || progRdAddr == `ESC_ADDR_RSVB)
            rdData_d = `ESC_RSV_VALUE;
        else if (progRdAddr <= `ESC_ADDR_GLOBAL)
            rdData_d = eff[progRdAddr];
        else
            rdData_d = 16'h0000;
    end

    // ----------------------------------------
    // Priority classification
    // ----------------------------------------
    esc_port_cfg_t qCfg;
    assign qCfg = portCfg[(prioQuery.port > 3'd5) ? 3'd5 : prioQuery.port];

    always_comb
    begin
        prioValid_d = prioQuery.valid;
        prio_d = qCfg.portPrio;
        if (qCfg.portPrioOnly || !tagMode)
            prio_d = qCfg.portPrio;
        else if (qCfg.tosFirst && prioQuery.hasTos)
            prio_d = prioQuery.tosPrio;
        // Only reached in tag mode
        else if (prioQuery.hasVlan)
            prio_d = prioQuery.vlanPrio;
        else if (prioQuery.hasTos)
            prio_d = prioQuery.tosPrio;
        else
            prio_d = qCfg.portPrio;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            xoSync_q <= 3'h0;
            fxSync_q <= 3'h0;
            strapCnt_q <= 2'h0;
            xoStrap_q <= 1'b0;
            fxStrap_q <= 1'b0;
            state_q <= ST_STRAP;
            addr_q <= 4'h0;
            sigBad_q <= 1'b0;
            rdData_q <= 16'h0000;
            prio_q <= 2'h0;
            prioValid_q <= 1'b0;
            for (int i = 1; i <= 11; i++)
                words_q[i] <= resetVal(4'(i));
        end
        else
        begin
            xoSync_q <= xoSync_d;
            fxSync_q <= fxSync_d;
            strapCnt_q <= strapCnt_d;
            xoStrap_q <= xoStrap_d;
            fxStrap_q <= fxStrap_d;
            state_q <= state_d;
            addr_q <= addr_d;
            sigBad_q <= sigBad_d;
            rdData_q <= rdData_d;
            prio_q <= prio_d;
            prioValid_q <= prioValid_d;
            for (int i = 1; i <= 11; i++)
                words_q[i] <= words_d[i];
        end
    end

    // ----------------------------------------
    // Decoded outputs
    // ----------------------------------------
    generate
        for (genvar p = 0; p < `ESC_NUM_PORTS; p++)
        begin : g_port
            logic [15:0] w;
            assign w = eff[portAddr(p)];
            assign portCfg[p].autoMdix = xoStrap_q | w[`ESC_B_XOVER];
            if (p == `ESC_NUM_PORTS - 1)
            begin : g_fx
                assign portCfg[p].fiberMediaMode = fxStrap_q | w[`ESC_B_FIBER];
            end
            else
            begin : g_tp
                assign portCfg[p].fiberMediaMode = w[`ESC_B_FIBER];
            end
            assign portCfg[p].pvidLow = w[`ESC_B_PORT_DEFAULT_VLAN_ID_HI:`ESC_B_PORT_DEFAULT_VLAN_ID_LO];
            assign portCfg[p].portPrio = w[`ESC_B_PRIO_HI:`ESC_B_PRIO_LO];
            assign portCfg[p].portPrioOnly = w[`ESC_B_PORTPRIO];
            assign portCfg[p].tosFirst = w[`ESC_B_TOSFIRST];
            assign portCfg[p].portDisable = w[`ESC_B_DISABLE];
            assign portCfg[p].egressTag = w[`ESC_B_TAG];
            assign portCfg[p].fullDuplex = w[`ESC_B_DUPLEX];
            assign portCfg[p].speed100 = w[`ESC_B_SPEED];
            assign portCfg[p].autoNeg = w[`ESC_B_ANEG];
            assign portCfg[p].flowCtl = w[`ESC_B_FLOW];
        end
    endgenerate

    assign vidReplace = eff[`ESC_ADDR_VIDOPT][`ESC_B_VIDREPL];
    assign farEndFaultDisable = eff[`ESC_ADDR_GLOBAL][`ESC_B_FEFDIS];
    assign trunkEnable = eff[`ESC_ADDR_GLOBAL][`ESC_B_TRUNK];
    assign ipgBitTimes = eff[`ESC_ADDR_GLOBAL][`ESC_B_IPGLVL] ? `ESC_IPG_SHORT : `ESC_IPG_STD;
    assign eeAddr = addr_q;
    assign progRdData = rdData_q;
    assign prioQueue = prio_q;
    assign prioValid = prioValid_q;
    assign loadDone = (state_q == ST_DONE);
    assign signatureBad = sigBad_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_sig_readonly: assert property (@(posedge clock) disable iff (reset)
        progWrEn && progAddr == `ESC_ADDR_SIG ##1 progRdAddr == `ESC_ADDR_SIG
        |=> progRdData == SIGNATURE)
        else $error("signature word changed");
    a_sig_mismatch: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_FETCH && eeValid && addr_q == `ESC_ADDR_SIG && eeData != SIGNATURE
        |=> loadDone && signatureBad && portCfg[0].pvidLow == 4'h1 && !eeReq)
        else $error("mismatch did not abandon load");
    a_load_order: assert property (@(posedge clock) disable iff (reset)
        eeReq && eeValid && !$rose(eeReq) && eeAddr != `ESC_ADDR_LAST && !signatureBad
        ##1 eeReq |-> eeAddr == $past(eeAddr) + 4'd1)
        else $error("words not loaded in order");
    a_hold_default: assert property (@(posedge clock) disable iff (reset)
        !loadDone |-> farEndFaultDisable && portCfg[2].speed100 && !trunkEnable)
        else $error("register left default before load end");
    a_xover_strap: assert property (@(posedge clock) disable iff (reset)
        xoStrap_q |-> portCfg[1].autoMdix && portCfg[4].autoMdix)
        else $error("strap crossover not applied");
    a_fiber_strap: assert property (@(posedge clock) disable iff (reset)
        fxStrap_q |-> portCfg[5].fiberMediaMode)
        else $error("fiber strap not applied");
    a_rsvd_fixed: assert property (@(posedge clock) disable iff (reset)
        progRdAddr == `ESC_ADDR_RSVB |=> progRdData == `ESC_RSV_VALUE)
        else $error("reserved word value wrong");
    a_rsvd_bits: assert property (@(posedge clock) disable iff (reset)
        progRdAddr == `ESC_ADDR_GLOBAL |=> (progRdData & ~`ESC_GLOBAL_MASK) == 16'h0000)
        else $error("reserved bits changed");
    a_port_prio: assert property (@(posedge clock) disable iff (reset)
        prioQuery.valid && qCfg.portPrioOnly |=> prioValid && prioQueue == $past(qCfg.portPrio))
        else $error("port priority not used");
    a_ipg_gap: assert property (@(posedge clock) disable iff (reset)
        loadDone && words_q[`ESC_ADDR_GLOBAL][`ESC_B_IPGLVL] |-> ipgBitTimes == `ESC_IPG_SHORT)
        else $error("gap length wrong");
    c_load_good: cover property (@(posedge clock) disable iff (reset)
        $rose(loadDone) && !signatureBad);
    c_load_bad: cover property (@(posedge clock) disable iff (reset)
        $rose(loadDone) && signatureBad);
    c_prog_write: cover property (@(posedge clock) disable iff (reset)
        loadDone && progWrEn && progAddr == `ESC_ADDR_GLOBAL);
    c_tos_first: cover property (@(posedge clock) disable iff (reset)
        prioQuery.valid && qCfg.tosFirst && prioQuery.hasTos && prioQuery.hasVlan);

endmodule

/* tb/esc_ee_model.sv */
// Configuration memory model answering word requests of the bank
`timescale 1ns/1ps

module esc_ee_model
#(
    parameter logic [15:0] SIG = 16'hA5C3
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Word reader
    input wire logic eeReq,
    input wire logic [3:0] eeAddr,
    output logic eeValid,
    output logic [15:0] eeData,
    // Bench controls and status
    input wire logic badSig,
    input wire logic slow,
    output logic orderErr,
    output logic [4:0] served
);
    logic [2:0] waitQ;
    logic [3:0] nextQ;

    function automatic logic [15:0] word(input logic [3:0] a);
        return {a, ~a, a ^ 4'h5, ~a};
    endfunction

    // Data toggles when idle so a stale word is never mistaken for a fresh one
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            eeValid <= 1'b0;
            eeData <= 16'h0000;
            orderErr <= 1'b0;
            served <= 5'h00;
            waitQ <= 3'h0;
            nextQ <= 4'h0;
        end
        else if (eeReq && !eeValid && waitQ == (slow ? 3'h5 : 3'h0))
        begin
            eeValid <= 1'b1;
            eeData <= (eeAddr == 4'h0) ? (badSig ? ~SIG : SIG) : word(eeAddr);
            orderErr <= orderErr | (eeAddr != nextQ);
            nextQ <= eeAddr + 4'h1;
            served <= served + 5'h01;
            waitQ <= 3'h0;
        end
        else
        begin
            eeValid <= 1'b0;
            eeData <= ~eeData;
            waitQ <= (eeReq && !eeValid) ? waitQ + 3'h1 : 3'h0;
        end
    end
endmodule

/* tb/esc_config_bank_bench.sv */
// Self-checking bench for the switch configuration bank
`timescale 1ns/1ps
`include "esc_consts.svh"

module esc_config_bank_bench import esc_pkg::*;;
    localparam logic [15:0] SIG = `ESC_SIG_DEFAULT;
    localparam logic [3:0] PORT_ADDR [0:5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic xStrap = 1'b0;
    logic fStrap = 1'b0;
    logic badSig = 1'b0;
    logic slow = 1'b0;
    logic progWrEn = 1'b0;
    logic tagMode = 1'b0;
    logic [3:0] progAddr = 4'h0;
    logic [3:0] progRdAddr = 4'h0;
    logic [15:0] progWrData = 16'h0000;
    esc_prio_query_t prioQuery = '0;
    logic eeReq, eeValid, prioValid, vidReplace, fefDis, trunk, loadDone, sigBad, orderErr;
    logic [3:0] eeAddr;
    logic [15:0] eeData, progRdData;
    logic [1:0] prioQueue;
    logic [6:0] ipg;
    logic [4:0] served;
    esc_port_cfg_t [5:0] portCfg;
    int n_mismatch = 0;
    int check_count = 0;

    always #5 clock = ~clock;

    esc_config_bank #(.SIGNATURE(SIG)) u_esc_config_bank (.clock(clock), .reset(reset),
        .crossoverStrapPin(xStrap), .portSevenFiberStrap(fStrap), .eeReq(eeReq),
        .eeAddr(eeAddr), .eeValid(eeValid), .eeData(eeData), .progWrEn(progWrEn),
        .progAddr(progAddr), .progWrData(progWrData), .progRdAddr(progRdAddr),
        .progRdData(progRdData), .tagMode(tagMode), .prioQuery(prioQuery),
        .prioValid(prioValid), .prioQueue(prioQueue), .portCfg(portCfg),
        .vidReplace(vidReplace), .farEndFaultDisable(fefDis), .trunkEnable(trunk),
        .ipgBitTimes(ipg), .loadDone(loadDone), .signatureBad(sigBad));

    esc_ee_model #(.SIG(SIG)) u_esc_ee_model (.clock(clock), .reset(reset), .eeReq(eeReq),
        .eeAddr(eeAddr), .eeValid(eeValid), .eeData(eeData), .badSig(badSig),
        .slow(slow), .orderErr(orderErr), .served(served));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] ew(input logic [3:0] a);
        return {a, ~a, a ^ 4'h5, ~a};
    endfunction

    // Read value of a word holding w, with fixed fields forced
    function automatic logic [15:0] val(input logic [3:0] a, input logic [15:0] w);
        case (a)
            4'h0: return SIG;
            4'hA: return 16'h5902 & ~16'h0200 | w & 16'h0200;
            4'hB: return w & 16'h80C0;
            4'hC, 4'hD: return 16'h0FA5;
            4'hE, 4'hF: return 16'h0000;
            default: return w;
        endcase
    endfunction

    function automatic logic [15:0] dfw(input logic [3:0] a);
        return (a == 4'hA) ? 16'h5902 : (a == 4'hB) ? 16'h8000 : 16'h040F;
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic xs, input logic fs, input logic bs, input logic sl);
        @(negedge clock);
        reset = 1'b1;
        xStrap = xs;
        fStrap = fs;
        badSig = bs;
        slow = sl;
        repeat (8) @(negedge clock);
        reset = 1'b0;
    endtask

    // Bounded wait; a hang counts as a mismatch
    task automatic wait_done();
        int i;
        for (i = 0; i < 400 && loadDone !== 1'b1; i++)
            @(negedge clock);
        chk("loadDone", {15'h0, loadDone}, 16'h0001);
        if (loadDone !== 1'b1)
            close_out();
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clock);
        progWrEn = 1'b1;
        progAddr = a;
        progWrData = d;
        @(negedge clock);
        progWrEn = 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(negedge clock);
        progRdAddr = a;
        @(negedge clock);
        chk("progRdData", progRdData, exp);
    endtask

    task automatic gl(input logic t, input logic i, input logic f);
        chk("trunkEnable", {15'h0, trunk}, {15'h0, t});
        chk("ipgBitTimes", {9'h0, ipg}, i ? 16'd92 : 16'd96);
        chk("farEndFaultDisable", {15'h0, fefDis}, {15'h0, f});
    endtask

    task automatic prio(input logic t, input logic [15:0] w, input logic hv,
        input logic [1:0] vp, input logic ht, input logic [1:0] tp, input logic [1:0] q);
        wr(4'h3, w);
        @(negedge clock);
        tagMode = t;
        prioQuery = '{valid: 1'b1, port: 3'd1, hasVlan: hv, vlanPrio: vp, hasTos: ht,
            tosPrio: tp};
        @(negedge clock);
        chk("prioValid", {15'h0, prioValid}, 16'h0001);
        chk("prioQueue", {14'h0, prioQueue}, {14'h0, q});
        prioQuery.valid = 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        do_reset(1'b0, 1'b0, 1'b0, 1'b1);
        for (int a = 0; a < 14; a++)
            rdchk(4'(a), val(4'(a), dfw(4'(a))));
        chk("loadDone", {15'h0, loadDone}, 16'h0000);
        chk("portCfg0", portCfg[0], 16'h040F);
        gl(1'b0, 1'b0, 1'b1);
        $display("t_defaults done");
    endtask

    task automatic t_load();
        logic [15:0] wa;
        logic [15:0] wb;
        wa = ew(4'hA);
        wb = ew(4'hB);
        wait_done();
        chk("signatureBad", {15'h0, sigBad}, 16'h0000);
        chk("orderErr", {15'h0, orderErr}, 16'h0000);
        chk("served", {11'h0, served}, 16'd14);
        for (int i = 0; i < 6; i++)
            chk("portCfg", portCfg[i], ew(PORT_ADDR[i]));
        for (int a = 0; a < 16; a++)
            rdchk(4'(a), val(4'(a), ew(4'(a))));
        chk("vidReplace", {15'h0, vidReplace}, {15'h0, wa[9]});
        gl(wb[7], wb[6], wb[15]);
        $display("t_load done");
    endtask

    task automatic t_writes();
        wr(4'h0, ~SIG);
        rdchk(4'h0, SIG);
        wr(4'hC, 16'h0000);
        rdchk(4'hC, 16'h0FA5);
        wr(4'hD, 16'hFFFF);
        rdchk(4'hD, 16'h0FA5);
        wr(4'hB, 16'hFFFF);
        gl(1'b1, 1'b1, 1'b1);
        rdchk(4'hB, 16'h80C0);
        wr(4'hB, 16'h0000);
        gl(1'b0, 1'b0, 1'b0);
        wr(4'hA, 16'hFFFF);
        chk("vidReplace", {15'h0, vidReplace}, 16'h0001);
        rdchk(4'hA, 16'h5B02);
        wr(4'h9, 16'h1234);
        chk("portCfg5", portCfg[5], 16'h1234);
        wr(4'h2, 16'hABCD);
        rdchk(4'h2, 16'hABCD);
        $display("t_writes done");
    endtask

    task automatic t_prio();
        prio(1'b1, 16'h0280, 1'b1, 2'd3, 1'b1, 2'd1, 2'd2);
        prio(1'b1, 16'h0140, 1'b1, 2'd3, 1'b1, 2'd0, 2'd0);
        prio(1'b1, 16'h0100, 1'b1, 2'd3, 1'b1, 2'd0, 2'd3);
        prio(1'b0, 16'h0100, 1'b1, 2'd3, 1'b0, 2'd0, 2'd1);
        prio(1'b1, 16'h0140, 1'b0, 2'd2, 1'b0, 2'd2, 2'd1);
        prio(1'b0, 16'h0100, 1'b1, 2'd3, 1'b1, 2'd2, 2'd1);
        prio(1'b1, 16'h0100, 1'b0, 2'd3, 1'b1, 2'd2, 2'd2);
        $display("t_prio done");
    endtask

    // Straps high and a bad signature: load is abandoned after word zero
    task automatic t_badsig();
        do_reset(1'b1, 1'b1, 1'b1, 1'b0);
        wait_done();
        chk("signatureBad", {15'h0, sigBad}, 16'h0001);
        chk("served", {11'h0, served}, 16'd1);
        chk("portCfg0", portCfg[0], 16'h840F);
        chk("portCfg4", portCfg[4], 16'h840F);
        chk("portCfg5", portCfg[5], 16'hC40F);
        rdchk(4'h3, 16'h040F);
        gl(1'b0, 1'b0, 1'b1);
        $display("t_badsig done");
    endtask

    initial
    begin
        t_defaults();
        t_load();
        t_writes();
        t_prio();
        t_badsig();
        close_out();
    end
endmodule
